// File: pbcd_pkg.sv
/*
 * Constants and register map of the port B change-detect GPIO block.
 * Assumes a single 100 MHz clock and a plain register port on the core side.
 */
// Summary of operation
// - Eight-pin bidirectional port; a set direction bit makes that pin an input.
// - A clear direction bit drives the output latch value onto the pin.
// - Clearing the active-low pull-up control bit 7 enables the weak pull-ups of all input pins.
// - A pin configured as output never has its pull-up enabled.
// - Reset leaves the pull-up control in its disabled state.
// - Change detection covers only the upper four pins, and only inputs.
// - Each port read latches the upper pins; live inputs compare against it.
// - The ORed mismatches set the change flag at bit 0 of interrupt control.
// - A pending change condition raises the wake request out of power-down.
// - Any port read or write refreshes the snapshot, ending the mismatch.
// - A lasting mismatch keeps setting the flag; read first, then clear.
// - Optionally, a change coinciding with a read's second phase is missed.
// - Pin 0 serves as external interrupt input, Schmitt type when enabled.
// - In programming mode pins 6 and 7 are clock and data, Schmitt type.
package pbcd_pkg;
    localparam int PBCD_WIDTH = 8;
    localparam logic [2:0] PBCD_ADDR_PORT = 3'h0;
    localparam logic [2:0] PBCD_ADDR_DIR = 3'h1;
    localparam logic [2:0] PBCD_ADDR_OPTION = 3'h2;
    localparam logic [2:0] PBCD_ADDR_IRQCTL = 3'h3;
    localparam logic [2:0] PBCD_ADDR_MODE = 3'h4;
    localparam int PBCD_PULLUP_BIT = 7;
    localparam int PBCD_FLAG_BIT = 0;
    localparam int PBCD_MODE_EXTIRQ_BIT = 0;
    localparam int PBCD_MODE_MISS_BIT = 1;
    localparam int PBCD_CHG_LO = 4;
    localparam logic [7:0] PBCD_DIR_RST = 8'hff;
    localparam logic [7:0] PBCD_OPTION_RST = 8'hff;
    localparam logic [7:0] PBCD_LATCH_RST = 8'h00;
endpackage

// File: pbcd_sync.sv
/*
 * Two-flip-flop synchroniser for a bus of pin inputs.
 * Assumes the inputs are asynchronous to sys_clk.
 */
`timescale 1ns/1ps
module pbcd_sync
    import pbcd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [PBCD_WIDTH-1:0] async_in,
    output logic [PBCD_WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [PBCD_WIDTH-1:0] meta;
        logic [PBCD_WIDTH-1:0] stable;
    } pbcd_sync_type;

    pbcd_sync_type state_r;
    pbcd_sync_type state_nxt;

    always_comb begin
        state_nxt.meta = async_in;
        state_nxt.stable = state_r.meta;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign sync_out = state_r.stable;
endmodule

// File: pbcd_gpio.sv
/*
 * Eight-pin port with direction mask, global weak pull-up control and a
 * change detector on the upper four pins, reached over a plain register port.
 * Assumes pin inputs are asynchronous and pass the local synchroniser, and
 * that the pad ring implements the pull-up and buffer-type selects it is given.
 */
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
module pbcd_gpio
    import pbcd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [PBCD_WIDTH-1:0] second_port_pins_in,
    output logic [PBCD_WIDTH-1:0] second_port_pins_out,
    output logic [PBCD_WIDTH-1:0] second_port_pins_oe,
    output logic [PBCD_WIDTH-1:0] pullup_en,
    input wire logic prog_mode,
    output logic ext_irq_pin,
    output logic ext_irq_schmitt,
    output logic [1:0] prog_schmitt,
    output logic prog_clk,
    output logic prog_data,
    output logic change_flag,
    output logic wake_req
);
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] direction_mask;
        logic [7:0] option;
        logic change_flag;
        logic extirq_en;
        logic miss_en;
        logic [3:0] snapshot;
        logic [7:0] rdata;
        logic [7:0] pins_out;
        logic [7:0] pins_oe;
        logic [7:0] pullup_en;
        logic ext_irq;
        logic ext_irq_st;
        logic [1:0] prog_st;
        logic prog_clk;
        logic prog_data;
        logic wake;
    } pbcd_state_type;

    pbcd_state_type state_r;
    pbcd_state_type state_nxt;
    logic [PBCD_WIDTH-1:0] pins_sync;
    logic [3:0] mismatch;
    logic any_mismatch;
    logic port_access;

    pbcd_sync u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .async_in(second_port_pins_in),
        .sync_out(pins_sync)
    );

    function automatic logic [7:0] pbcd_read_mux(
        input logic [2:0] addr,
        input pbcd_state_type s,
        input logic [7:0] pins
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (addr)
            PBCD_ADDR_PORT: v = pins;
            PBCD_ADDR_DIR: v = s.direction_mask;
            PBCD_ADDR_OPTION: v = s.option;
            PBCD_ADDR_IRQCTL: v = {7'h00, s.change_flag};
            PBCD_ADDR_MODE: v = {6'h00, s.miss_en, s.extirq_en};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        state_nxt = state_r;
        port_access = (reg_rd || reg_wr) && (reg_addr == PBCD_ADDR_PORT);
        // Inputs only on the upper pins; outputs are masked out of the compare.
        mismatch = (pins_sync[7:PBCD_CHG_LO] ^ state_r.snapshot)
            & state_r.direction_mask[7:PBCD_CHG_LO];
        any_mismatch = |mismatch;

        if (reg_wr) begin
            unique case (reg_addr)
                PBCD_ADDR_PORT: state_nxt.latch = reg_wdata;
                PBCD_ADDR_DIR: state_nxt.direction_mask = reg_wdata;
                PBCD_ADDR_OPTION: state_nxt.option = reg_wdata;
                PBCD_ADDR_IRQCTL: state_nxt.change_flag = reg_wdata[PBCD_FLAG_BIT];
                PBCD_ADDR_MODE: begin
                    state_nxt.extirq_en = reg_wdata[PBCD_MODE_EXTIRQ_BIT];
                    state_nxt.miss_en = reg_wdata[PBCD_MODE_MISS_BIT];
                end
                default: begin
                end
            endcase
        end

        // Snapshot refresh ends the mismatch; polling would hide key presses.
        if (port_access) begin
            state_nxt.snapshot = pins_sync[7:PBCD_CHG_LO];
        end

        // Set wins over a software clear, so the flag cannot be cleared while
        // a mismatch remains. The optional miss mode drops sets during port reads.
        if (any_mismatch && !(state_r.miss_en && reg_rd && port_access)) begin
            state_nxt.change_flag = 1'b1;
        end

        if (reg_rd) begin
            state_nxt.rdata = pbcd_read_mux(reg_addr, state_r, pins_sync);
        end else begin
            state_nxt.rdata = 8'h00;
        end

        state_nxt.pins_oe = ~state_nxt.direction_mask;
        state_nxt.pins_out = state_nxt.latch;
        state_nxt.pullup_en = {PBCD_WIDTH{~state_nxt.option[PBCD_PULLUP_BIT]}}
            & state_nxt.direction_mask;
        state_nxt.ext_irq = pins_sync[0];
        state_nxt.ext_irq_st = state_nxt.extirq_en;
        state_nxt.prog_st = {2{prog_mode}};
        state_nxt.prog_clk = prog_mode & pins_sync[6];
        state_nxt.prog_data = prog_mode & pins_sync[7];
        state_nxt.wake = state_nxt.change_flag;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r.latch <= PBCD_LATCH_RST;
            state_r.direction_mask <= PBCD_DIR_RST;
            state_r.option <= PBCD_OPTION_RST;
            state_r.change_flag <= 1'b0;
            state_r.extirq_en <= 1'b0;
            state_r.miss_en <= 1'b0;
            state_r.snapshot <= 4'h0;
            state_r.rdata <= 8'h00;
            state_r.pins_out <= PBCD_LATCH_RST;
            state_r.pins_oe <= 8'h00;
            state_r.pullup_en <= 8'h00;
            state_r.ext_irq <= 1'b0;
            state_r.ext_irq_st <= 1'b0;
            state_r.prog_st <= 2'h0;
            state_r.prog_clk <= 1'b0;
            state_r.prog_data <= 1'b0;
            state_r.wake <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign reg_rdata = state_r.rdata;
    assign second_port_pins_out = state_r.pins_out;
    assign second_port_pins_oe = state_r.pins_oe;
    assign pullup_en = state_r.pullup_en;
    assign ext_irq_pin = state_r.ext_irq;
    assign ext_irq_schmitt = state_r.ext_irq_st;
    assign prog_schmitt = state_r.prog_st;
    assign prog_clk = state_r.prog_clk;
    assign prog_data = state_r.prog_data;
    assign change_flag = state_r.change_flag;
    assign wake_req = state_r.wake;
endmodule

// File: pbcd_checker.sv
/* Assertions on the pins, pull-ups and change flag of pbcd_gpio.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module pbcd_checker
    import pbcd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [PBCD_WIDTH-1:0] second_port_pins_out,
    input wire logic [PBCD_WIDTH-1:0] second_port_pins_oe,
    input wire logic [PBCD_WIDTH-1:0] pullup_en,
    input wire logic prog_mode,
    input wire logic [1:0] prog_schmitt,
    input wire logic change_flag,
    input wire logic wake_req
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // One cycle covers the register stage; the outputs register from next-state values.
    dir_drive_a: assert property (
        reg_wr && reg_addr == PBCD_ADDR_DIR |=> second_port_pins_oe == ~$past(reg_wdata))
        else $error("enable wrong");
    latch_out_a: assert property (
        reg_wr && reg_addr == PBCD_ADDR_PORT |=> second_port_pins_out == $past(reg_wdata))
        else $error("latch wrong");
    pullup_sel_a: assert property (
        reg_wr && reg_addr == PBCD_ADDR_OPTION |=>
        pullup_en == ({8{~$past(reg_wdata[PBCD_PULLUP_BIT])}} & ~second_port_pins_oe))
        else $error("pull-up wrong");
    out_no_pull_a: assert property ((second_port_pins_oe & pullup_en) == 8'h00)
        else $error("pull-up on output");
    wake_follow_a: assert property (wake_req == change_flag)
        else $error("wake wrong");
    flag_hold_a: assert property (
        change_flag && !(reg_wr && reg_addr == PBCD_ADDR_IRQCTL) |=> change_flag)
        else $error("flag dropped");
    flag_read_a: assert property (
        reg_rd && reg_addr == PBCD_ADDR_IRQCTL |=> reg_rdata == {7'h00, $past(change_flag)})
        else $error("flag read wrong");
    prog_buf_a: assert property (
        $stable(prog_mode) && $past(rst_b) |-> prog_schmitt == {2{prog_mode}})
        else $error("prog buffer wrong");
    cover property ($rose(change_flag));
    cover property ($rose(wake_req));
    cover property (prog_mode && reg_rd);
endmodule
bind pbcd_gpio pbcd_checker pbcd_checker_inst (.*);

// File: pbcd_keypad.sv
/* Keypad switches and weak pull-ups on the port pins.
   Assumes the design's latch, enable and pull-up outputs. */
`timescale 1ns/1ps
module pbcd_keypad (
    input wire logic sys_clk,
    input wire logic [7:0] drv,
    input wire logic [7:0] oe,
    input wire logic [7:0] pu,
    input wire logic [7:0] key_on,
    input wire logic [7:0] key_lvl,
    output logic [7:0] pins
);
    // An open pin with no pull-up wanders, so it flips every cycle.
    logic fl = 1'b0;
    always @(posedge sys_clk) fl <= ~fl;
    assign pins = (oe & drv) | (~oe & key_on & key_lvl) | (~oe & ~key_on & (pu | {8{fl}}));
endmodule

// File: test_port_b_change_detect_gpio.sv
/* Self-checking bench for pbcd_gpio with a keypad model on its pins.
   Assumes the checker binds itself to the design. */
`timescale 1ns/1ps
module test_port_b_change_detect_gpio;
    import pbcd_pkg::*;
    logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, prog_mode = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_val, key_on = 8'hff, key_lvl = 8'h3c;
    logic [7:0] second_port_pins_in, second_port_pins_out, second_port_pins_oe, pullup_en;
    logic [1:0] prog_schmitt;
    logic ext_irq_pin, ext_irq_schmitt, prog_clk, prog_data, change_flag, wake_req;
    int err_total = 0, checks_done = 0;
    // Each row is address, write data, read-back value; 5 and 7 are unmapped.
    logic [18:0] rows [5] = '{19'h10f0f, 19'h27f7f, 19'h40101, 19'h5a500, 19'h7ff00};
    pbcd_gpio pbcd_gpio_inst (.*);
    pbcd_keypad pbcd_keypad_inst (.sys_clk(sys_clk), .drv(second_port_pins_out),
        .oe(second_port_pins_oe), .pu(pullup_en), .key_on(key_on), .key_lvl(key_lvl),
        .pins(second_port_pins_in));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial forever #5 sys_clk = ~sys_clk;
    initial begin
        #20000;
        err_total++;
        finish_test;
    end
    initial begin
        idle(2);
        rst_b <= 1'b1;
        chk(pullup_en, 8'h00);
        chk(second_port_pins_oe, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i][18:16], rows[i][15:8]);
            rd(rows[i][18:16]);
            chk(rd_val, rows[i][7:0]);
        end
        key_on <= 8'hf0;
        wr(PBCD_ADDR_PORT, 8'ha5);
        idle(3);
        chk(pullup_en, 8'h0f);
        chk(8'(ext_irq_schmitt), 8'h01);
        rd(PBCD_ADDR_PORT);
        chk(rd_val, 8'haf);
        key_on <= 8'hff;
        wr(PBCD_ADDR_DIR, 8'hff);
        idle(4);
        rd(PBCD_ADDR_PORT);
        wr(PBCD_ADDR_IRQCTL, 8'h00);
        idle(2);
        chk(8'(change_flag), 8'h00);
        key_lvl <= 8'h34;
        idle(6);
        chk(8'(change_flag), 8'h00);
        key_lvl <= 8'hb4;
        idle(6);
        chk(8'(wake_req), 8'h01);
        wr(PBCD_ADDR_IRQCTL, 8'h00);
        rd(PBCD_ADDR_IRQCTL);
        chk(rd_val, 8'h01);
        // Software reads the port once, then clears; it never polls.
        rd(PBCD_ADDR_PORT);
        wr(PBCD_ADDR_IRQCTL, 8'h00);
        idle(2);
        chk(8'(change_flag), 8'h00);
        wr(PBCD_ADDR_DIR, 8'h7f);
        wr(PBCD_ADDR_PORT, 8'h25);
        idle(6);
        chk(8'(change_flag), 8'h00);
        chk(second_port_pins_out, 8'h25);
        chk(8'(ext_irq_pin), 8'h00);
        @(posedge sys_clk);
        prog_mode <= 1'b1;
        idle(4);
        chk({6'h00, prog_schmitt}, 8'h03);
        chk({6'h00, prog_clk, prog_data}, 8'h00);
        finish_test;
    end
endmodule
